// ---- hw/icupin_top.sv ----
// Pin-level interrupt unit: register port, trigger, pins and counters
`timescale 1ns/1ns
module icupin_top
    import icupin_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic high_byte_enable_n_i,
    input wire logic cpu_status_line_i,
    input wire logic [4:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic [7:0] odd_irq_inputs_i,
    input wire logic [7:0] shared_gp_pins_i,
    output logic [7:0] shared_gp_pins_o,
    output logic [7:0] shared_gp_pins_oe_o,
    input wire logic counter_clk_i,
    input wire logic counter_out_sample_in_i,
    output logic counter_out_sample_in_o,
    output logic counter_out_sample_in_oe_o,
    output logic int_n_o,
    output logic vector_acknowledge_cycle_o,
    output logic return_from_irq_cycle_o
);

    function automatic logic trig_hit(input logic [1:0] mode,
                                      input logic cur,
                                      input logic prev);
        logic hit;
        unique case (mode)
            TRIG_RISE: hit = cur & ~prev;
            TRIG_FALL: hit = ~cur & prev;
            TRIG_LOW: hit = ~cur;
            TRIG_HIGH: hit = cur;
        endcase
        return hit;
    endfunction

    // Reset release through two flops
    logic rst_s1_r, rst_n;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // Pin synchronisers
    icupin_bus_type bus_s1_r, bus_s2_r, bus_raw;
    logic [7:0] d_s1_r, d_s2_r, gp_s1_r, gp_s2_r, irq_s1_r, irq_s2_r;
    logic cclk_s1_r, cclk_s2_r, scin_s1_r, scin_s2_r;
    assign bus_raw = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
                       hbe_n: high_byte_enable_n_i,
                       status: cpu_status_line_i, addr: addr_i};
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_s1_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                          hbe_n: 1'b1, status: 1'b0, addr: 5'h00};
            bus_s2_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                          hbe_n: 1'b1, status: 1'b0, addr: 5'h00};
            {d_s1_r, d_s2_r, gp_s1_r, gp_s2_r} <= '0;
            {irq_s1_r, irq_s2_r} <= '0;
            {cclk_s1_r, cclk_s2_r, scin_s1_r, scin_s2_r} <= '0;
        end else begin
            bus_s1_r <= bus_raw;
            bus_s2_r <= bus_s1_r;
            d_s1_r <= data_i;
            d_s2_r <= d_s1_r;
            gp_s1_r <= shared_gp_pins_i;
            gp_s2_r <= gp_s1_r;
            irq_s1_r <= odd_irq_inputs_i;
            irq_s2_r <= irq_s1_r;
            cclk_s1_r <= counter_clk_i;
            cclk_s2_r <= cclk_s1_r;
            scin_s1_r <= counter_out_sample_in_i;
            scin_s2_r <= scin_s1_r;
        end
    end

    // State
    logic [7:0] regs_r [32];
    logic [7:0] regs_nxt [32];
    logic rd_prev_r, wr_prev_r, hbe_prev_r;
    logic [4:0] waddr_r;
    logic [7:0] wlo_r, whi_r, rlo_r, rhi_r;
    logic [15:0] pend_r, pend_nxt, samp_r, samp_nxt;
    logic [15:0] lcnt_r, lcnt_nxt, hcnt_r, hcnt_nxt;
    logic [1:0] presc_r, presc_nxt;
    logic [5:0] osc_cnt_r, osc_cnt_nxt;
    logic osc_r, osc_nxt, cclk_prev_r, scin_prev_r;
    logic [7:0] rlo_nxt, rhi_nxt, gp_o_nxt, gp_oe_nxt;
    logic ack_nxt, return_from_irq_cycle_nxt, cout_nxt;

    logic rd_act, wr_act, rd_start, wr_evt, vec_rd, wide, pin_dir_ctrl;
    logic samp_tick, cnt_tick, lzero, hzero;
    logic [7:0] pin_function_select, port_direction, ocasn, cctl, vector;
    logic [15:0] set_v, clr_v;
    logic [31:0] tmode;

    assign wide = regs_r[ADDR_MODE][MODE_WIDE_BIT];
    assign pin_dir_ctrl = regs_r[ADDR_MODE][MODE_PIN_DIR_BIT];
    assign pin_function_select = regs_r[ADDR_PIN_FUNC];
    assign port_direction = regs_r[ADDR_PORT_DIR];
    assign ocasn = regs_r[ADDR_OUTASN];
    assign cctl = regs_r[ADDR_CNT_CTRL];
    assign tmode = {regs_r[ADDR_TMODE0 + 5'h03], regs_r[ADDR_TMODE0 + 5'h02],
                    regs_r[ADDR_TMODE0 + 5'h01], regs_r[ADDR_TMODE0]};
    assign rd_act = ~bus_s2_r.cs_n & ~bus_s2_r.rd_n;
    assign wr_act = ~bus_s2_r.cs_n & ~bus_s2_r.wr_n;
    assign rd_start = rd_act & ~rd_prev_r;
    assign wr_evt = wr_prev_r & ~wr_act;
    assign vec_rd = rd_start & (bus_s2_r.addr == ADDR_VECTOR);
    assign lzero = (lcnt_r == 16'h0000);
    assign hzero = (hcnt_r == 16'h0000);

    always_comb begin
        vector = NO_VECTOR;
        for (int i = 15; i >= 0; i--) begin
            if (pend_r[i]) begin
                vector = 8'(i);
            end
        end
    end

    function automatic logic [7:0] reg_read(input logic [4:0] a);
        logic [7:0] v;
        v = regs_r[a];
        if (a == ADDR_VECTOR) begin
            v = vector;
        end else if (a == ADDR_PEND_LO) begin
            v = pend_r[7:0];
        end else if (a == ADDR_PEND_HI) begin
            v = pend_r[15:8];
        end else if (a == ADDR_PORT_DATA) begin
            v = gp_s2_r;
        end else if (a == ADDR_LCUR) begin
            v = lcnt_r[7:0];
        end else if (a == ADDR_LCUR + 5'h01) begin
            v = lcnt_r[15:8];
        end else if (a == ADDR_HCUR) begin
            v = hcnt_r[7:0];
        end else if (a == ADDR_HCUR + 5'h01) begin
            v = hcnt_r[15:8];
        end
        return v;
    endfunction

    // Register file and bus
    always_comb begin
        regs_nxt = regs_r;
        rlo_nxt = rlo_r;
        rhi_nxt = rhi_r;
        if (wr_evt) begin
            regs_nxt[waddr_r] = wlo_r;
            if (wide && !hbe_prev_r) begin
                regs_nxt[waddr_r | 5'h01] = whi_r;
            end
        end
        if (rd_start) begin
            rlo_nxt = reg_read(bus_s2_r.addr);
            rhi_nxt = reg_read(bus_s2_r.addr | 5'h01);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                regs_r[i] <= RST_OTHER;
            end
            regs_r[ADDR_PIN_FUNC] <= RST_PIN_FUNC;
            regs_r[ADDR_PORT_DIR] <= RST_PORT_DIR;
            {rd_prev_r, wr_prev_r, hbe_prev_r} <= 3'h1;
            waddr_r <= 5'h00;
            {wlo_r, whi_r, rlo_r, rhi_r} <= '0;
        end else begin
            regs_r <= regs_nxt;
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
            rlo_r <= rlo_nxt;
            rhi_r <= rhi_nxt;
            if (wr_act) begin
                waddr_r <= bus_s2_r.addr;
                wlo_r <= d_s2_r;
                whi_r <= gp_s2_r;
                hbe_prev_r <= bus_s2_r.hbe_n;
            end
        end
    end

    // Sampling clock and interrupt trigger
    always_comb begin
        osc_cnt_nxt = osc_cnt_r + 6'h01;
        osc_nxt = osc_r;
        if (osc_cnt_r == OSC_HALF_CYC - 6'h01) begin
            osc_cnt_nxt = 6'h00;
            osc_nxt = ~osc_r;
        end
        if (pin_dir_ctrl) begin
            samp_tick = scin_s2_r & ~scin_prev_r;
        end else begin
            samp_tick = osc_nxt & ~osc_r;
        end
        for (int k = 0; k < 8; k++) begin
            samp_nxt[2 * k] = gp_s2_r[k];
            samp_nxt[2 * k + 1] = irq_s2_r[k];
        end
        set_v = '0;
        clr_v = '0;
        for (int p = 0; p < 16; p++) begin
            if (trig_hit(tmode[2 * p +: 2], samp_nxt[p], samp_r[p])) begin
                set_v[p] = 1'b1;
            end
        end
        // shared pin as irq only if selected
        for (int k = 0; k < 8; k++) begin
            if (wide || !pin_function_select[k] || (k < 4 && ocasn[k])) begin
                set_v[2 * k] = 1'b0;
            end
            if (pin_function_select[k] && !regs_nxt[ADDR_PIN_FUNC][k]) begin
                clr_v[2 * k] = 1'b1;
            end
        end
        if (!samp_tick) begin
            set_v = '0;
        end
        if (vec_rd && !bus_s2_r.status && vector != NO_VECTOR) begin
            clr_v[vector[3:0]] = 1'b1;
        end
        pend_nxt = (pend_r & ~clr_v) | set_v;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_r <= 6'h00;
            osc_r <= 1'b0;
            scin_prev_r <= 1'b0;
            samp_r <= '0;
            pend_r <= '0;
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
            osc_r <= osc_nxt;
            scin_prev_r <= scin_s2_r;
            if (samp_tick) begin
                samp_r <= samp_nxt;
            end
            pend_r <= pend_nxt;
        end
    end

    // Counters
    always_comb begin
        cnt_tick = 1'b0;
        presc_nxt = presc_r;
        lcnt_nxt = lcnt_r;
        hcnt_nxt = hcnt_r;
        if (cclk_s2_r && !cclk_prev_r) begin
            presc_nxt = presc_r + 2'h1;
            cnt_tick = cctl[CC_BYPASS_BIT] || (presc_r == PRESC_LAST);
        end
        if (cnt_tick && cctl[CC_RUNL_BIT]) begin
            lcnt_nxt = lzero ? {regs_r[ADDR_LSTART + 5'h01],
                                regs_r[ADDR_LSTART]} : lcnt_r - 16'h0001;
        end
        if (cnt_tick && cctl[CC_RUNH_BIT]) begin
            hcnt_nxt = hzero ? {regs_r[ADDR_HSTART + 5'h01],
                                regs_r[ADDR_HSTART]} : hcnt_r - 16'h0001;
        end
        if (wr_evt && !cctl[CC_RUNL_BIT]) begin
            if (waddr_r == ADDR_LCUR) begin
                lcnt_nxt[7:0] = wlo_r;
            end else if (waddr_r == ADDR_LCUR + 5'h01) begin
                lcnt_nxt[15:8] = wlo_r;
            end
        end
        if (wr_evt && !cctl[CC_RUNH_BIT]) begin
            if (waddr_r == ADDR_HCUR) begin
                hcnt_nxt[7:0] = wlo_r;
            end else if (waddr_r == ADDR_HCUR + 5'h01) begin
                hcnt_nxt[15:8] = wlo_r;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            presc_r <= 2'h0;
            cclk_prev_r <= 1'b0;
            lcnt_r <= 16'h0000;
            hcnt_r <= 16'h0000;
        end else begin
            presc_r <= presc_nxt;
            cclk_prev_r <= cclk_s2_r;
            lcnt_r <= lcnt_nxt;
            hcnt_r <= hcnt_nxt;
        end
    end

    // Pin outputs
    always_comb begin
        gp_o_nxt = '0;
        gp_oe_nxt = '0;
        unique case (cctl[CC_SEL_LSB +: 2])
            ZSEL_OSC: cout_nxt = osc_r;
            ZSEL_LOW: cout_nxt = lzero;
            ZSEL_HIGH: cout_nxt = hzero;
            ZSEL_EITHER: cout_nxt = lzero | hzero;
        endcase
        if (wide) begin
            gp_o_nxt = rhi_r;
            gp_oe_nxt = {8{rd_act && rd_prev_r && !bus_s2_r.hbe_n}};
        end else begin
            for (int k = 0; k < 8; k++) begin
                if (!pin_function_select[k] && !port_direction[k]) begin
                    gp_o_nxt[k] = regs_r[ADDR_PORT_DATA][k];
                    gp_oe_nxt[k] = 1'b1;
                end
                // high counter on low four pins
                if (k < 4 && ocasn[k]) begin
                    gp_o_nxt[k] = hzero;
                    gp_oe_nxt[k] = 1'b1;
                end
            end
        end
        ack_nxt = vec_rd && !bus_s2_r.status;
        return_from_irq_cycle_nxt = vec_rd && bus_s2_r.status;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
            shared_gp_pins_o <= 8'h00;
            shared_gp_pins_oe_o <= 8'h00;
            counter_out_sample_in_o <= 1'b0;
            counter_out_sample_in_oe_o <= 1'b0;
            int_n_o <= 1'b1;
            vector_acknowledge_cycle_o <= 1'b0;
            return_from_irq_cycle_o <= 1'b0;
        end else begin
            data_o <= rlo_r;
            data_oe_o <= rd_act && rd_prev_r;
            shared_gp_pins_o <= gp_o_nxt;
            shared_gp_pins_oe_o <= gp_oe_nxt;
            counter_out_sample_in_o <= cout_nxt;
            counter_out_sample_in_oe_o <= ~pin_dir_ctrl;
            int_n_o <= ~(|pend_r);
            vector_acknowledge_cycle_o <= ack_nxt;
            return_from_irq_cycle_o <= return_from_irq_cycle_nxt;
        end
    end

    a_reset_narrow: assert property (@(posedge clk_i)
        (rst_n && !$past(rst_n)) |-> (!wide && pin_function_select == RST_PIN_FUNC))
        else $error("bus not narrow after reset");
    a_int_level: assert property (@(posedge clk_i) disable iff (!rst_n)
        (|pend_r) |=> !int_n_o)
        else $error("int output not low while pending");
    a_data_drive: assert property (@(posedge clk_i) disable iff (!rst_n)
        data_oe_o |-> $past(rd_act, 1) && $past(rd_act, 2))
        else $error("data driven outside a read");
    a_write_sel: assert property (@(posedge clk_i) disable iff (!rst_n)
        $changed(port_direction) |-> $past(wr_evt))
        else $error("register changed without a write");
    a_high_byte: assert property (@(posedge clk_i) disable iff (!rst_n)
        (wide && |shared_gp_pins_oe_o) |-> $past(!bus_s2_r.hbe_n))
        else $error("high byte driven without enable");
    a_port_out: assert property (@(posedge clk_i) disable iff (!rst_n)
        (!wide && !pin_function_select[7] && !port_direction[7]) |=> shared_gp_pins_oe_o[7])
        else $error("port output not driven");
    a_prescale_div: assert property (@(posedge clk_i) disable iff (!rst_n)
        (cnt_tick && !cctl[CC_BYPASS_BIT]) |-> presc_r == PRESC_LAST)
        else $error("prescaler tick off count");
    a_ack_cycle: assert property (@(posedge clk_i) disable iff (!rst_n)
        (vec_rd && !bus_s2_r.status) |=> vector_acknowledge_cycle_o
        && !return_from_irq_cycle_o)
        else $error("acknowledge cycle missing");
    a_osc_half: assert property (@(posedge clk_i) disable iff (!rst_n)
        $changed(osc_r) |-> $past(osc_cnt_r) == OSC_HALF_CYC - 6'h01)
        else $error("oscillator half period wrong");

endmodule

// ---- hw/icupin_pkg.sv ----
// Constants and carrier types for the interrupt unit pin interface
package icupin_pkg;

    localparam logic [4:0] ADDR_VECTOR = 5'h00;
    localparam logic [4:0] ADDR_TMODE0 = 5'h08;
    localparam logic [4:0] ADDR_PEND_LO = 5'h04;
    localparam logic [4:0] ADDR_PEND_HI = 5'h05;
    localparam logic [4:0] ADDR_MODE = 5'h10;
    localparam logic [4:0] ADDR_OUTASN = 5'h11;
    localparam logic [4:0] ADDR_PORT_DATA = 5'h13;
    localparam logic [4:0] ADDR_PIN_FUNC = 5'h14;
    localparam logic [4:0] ADDR_PORT_DIR = 5'h15;
    localparam logic [4:0] ADDR_CNT_CTRL = 5'h16;
    localparam logic [4:0] ADDR_LSTART = 5'h18;
    localparam logic [4:0] ADDR_HSTART = 5'h1A;
    localparam logic [4:0] ADDR_LCUR = 5'h1C;
    localparam logic [4:0] ADDR_HCUR = 5'h1E;

    // Mode register fields
    localparam int MODE_WIDE_BIT = 0;
    localparam int MODE_PIN_DIR_BIT = 5;
    // Counter control fields
    localparam int CC_RUNL_BIT = 2;
    localparam int CC_RUNH_BIT = 3;
    localparam int CC_SEL_LSB = 4;
    localparam int CC_BYPASS_BIT = 6;

    localparam logic [7:0] RST_PIN_FUNC = 8'hFF;
    localparam logic [7:0] RST_PORT_DIR = 8'hFF;
    localparam logic [7:0] RST_OTHER = 8'h00;
    localparam logic [7:0] NO_VECTOR = 8'hFF;

    // Trigger codes, two bits per source
    localparam logic [1:0] TRIG_RISE = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_LOW = 2'h2;
    localparam logic [1:0] TRIG_HIGH = 2'h3;

    // Zero-out select codes
    localparam logic [1:0] ZSEL_OSC = 2'h0;
    localparam logic [1:0] ZSEL_LOW = 2'h1;
    localparam logic [1:0] ZSEL_HIGH = 2'h2;
    localparam logic [1:0] ZSEL_EITHER = 2'h3;

    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 400;
    localparam logic [5:0] OSC_HALF_CYC =
        6'(OSC_PERIOD_NS / CLK_PERIOD_NS / 2);
    localparam logic [1:0] PRESC_LAST = 2'h3;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic hbe_n;
        logic status;
        logic [4:0] addr;
    } icupin_bus_type;

endpackage

// ---- bench/icupin_cpu_model.sv ----
// Behavioural host processor on the asynchronous register port
`timescale 1ns/1ns
module icupin_cpu_model
    import icupin_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic [7:0] rhi_i,
    output icupin_bus_type bus_o,
    output logic [7:0] wdata_o,
    output logic [7:0] whi_o,
    output logic hi_en_o
);
    initial begin
        bus_o = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 5'h00};
        wdata_o = 8'h00;
        whi_o = 8'h00;
        hi_en_o = 1'b0;
    end

    // One strobe cycle; lanes are released with inverted values afterwards
    task automatic xfer(input logic wr, input logic sel_n,
        input logic hb_n, input logic st, input logic [4:0] a,
        input logic [15:0] d, output logic [15:0] q);
        @(negedge clk_i);
        bus_o.addr = a;
        bus_o.status = st;
        bus_o.hbe_n = hb_n;
        wdata_o = d[7:0];
        whi_o = d[15:8];
        hi_en_o = wr & ~hb_n;
        bus_o.cs_n = sel_n;
        if (wr) begin
            bus_o.wr_n = 1'b0;
        end else begin
            bus_o.rd_n = 1'b0;
        end
        repeat (6) @(posedge clk_i);
        // Read data is taken while it stands, away from the launch edge
        @(negedge clk_i);
        q = {rhi_i, rdata_i};
        bus_o.cs_n = 1'b1;
        bus_o.rd_n = 1'b1;
        bus_o.wr_n = 1'b1;
        repeat (5) @(negedge clk_i);
        wdata_o = ~d[7:0];
        whi_o = ~d[15:8];
        hi_en_o = 1'b0;
    endtask
endmodule

// ---- bench/icu_pin_level_host_interface_test.sv ----
// Self-checking bench for the interrupt unit pin interface
`timescale 1ns/1ns
module icu_pin_level_host_interface_test;
    import icupin_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] odd_irq = 8'h00;
    logic [7:0] gp_ext = 8'h00;
    logic cnt_clk = 1'b0;
    logic scin = 1'b0;
    icupin_bus_type bus;
    logic [7:0] d_i, d_o, hi_i, gp_o, gp_oe, gp_pins;
    logic d_oe, hi_en, cpin_o, cpin_oe, cpin_w, int_n, ack_p, ret_p;
    logic [15:0] q;
    int failures = 0;
    int n_compared = 0;
    int n_ack = 0;
    int n_ret = 0;

    always #5 clk = ~clk;
    always #50 cnt_clk = ~cnt_clk;
    assign gp_pins = (gp_oe & gp_o) | (~gp_oe & (hi_en ? hi_i : gp_ext));
    assign cpin_w = cpin_oe ? cpin_o : scin;

    icupin_cpu_model cpu (.clk_i(clk), .rdata_i(d_o), .rhi_i(gp_o),
        .bus_o(bus), .wdata_o(d_i), .whi_o(hi_i), .hi_en_o(hi_en));

    icupin_top uut (.clk_i(clk), .resetn_i(resetn), .cs_n_i(bus.cs_n),
        .rd_n_i(bus.rd_n), .wr_n_i(bus.wr_n),
        .high_byte_enable_n_i(bus.hbe_n), .cpu_status_line_i(bus.status),
        .addr_i(bus.addr), .data_i(d_i), .data_o(d_o), .data_oe_o(d_oe),
        .odd_irq_inputs_i(odd_irq), .shared_gp_pins_i(gp_pins),
        .shared_gp_pins_o(gp_o), .shared_gp_pins_oe_o(gp_oe),
        .counter_clk_i(cnt_clk), .counter_out_sample_in_i(cpin_w),
        .counter_out_sample_in_o(cpin_o),
        .counter_out_sample_in_oe_o(cpin_oe), .int_n_o(int_n),
        .vector_acknowledge_cycle_o(ack_p),
        .return_from_irq_cycle_o(ret_p));

    always @(negedge clk) begin
        if (ack_p === 1'b1) n_ack++;
        if (ret_p === 1'b1) n_ret++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        cpu.xfer(1'b1, 1'b0, 1'b1, 1'b0, a, {8'h00, d}, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic st);
        cpu.xfer(1'b0, 1'b0, 1'b1, st, a, 16'h0000, q);
    endtask

    task automatic wait_int(input logic lvl);
        int k;
        k = 0;
        while (int_n !== lvl && k < 400) begin
            @(posedge clk);
            k++;
        end
        check(16'(int_n), 16'(lvl)); // output follows pending
    endtask

    task automatic t_reset();
        check(16'(d_oe), 16'h0000); // bus released
        check(16'(int_n), 16'h0001); // none pending
        rd(ADDR_PIN_FUNC, 1'b0);
        check(q[7:0], RST_PIN_FUNC); // reset ones
        rd(ADDR_PORT_DIR, 1'b0);
        check(q[7:0], RST_PORT_DIR); // reset ones
        rd(ADDR_MODE, 1'b0);
        check(q[7:0], 8'h00); // narrow bus
    endtask

    task automatic t_regs();
        wr(ADDR_LSTART, 8'h5A);
        wr(ADDR_HSTART, 8'hA5);
        cpu.xfer(1'b1, 1'b1, 1'b1, 1'b0, ADDR_LSTART, 16'h00C3, q);
        rd(ADDR_LSTART, 1'b0);
        check(q[7:0], 8'h5A); // unselected write ignored
        check(16'(d_oe), 16'h0000); // released after read
        rd(ADDR_HSTART, 1'b0);
        check(q[7:0], 8'hA5); // distinct registers
    endtask

    task automatic t_modes();
        logic [3:0] act;
        logic [3:0] post;
        int k;
        act = 4'b1001;
        post = 4'b0101;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_TMODE0, {4'h0, 2'(i), 2'h0});
            @(negedge clk);
            odd_irq[0] = act[i];
            wait_int(1'b0); // mode triggers
            @(negedge clk);
            odd_irq[0] = post[i];
            repeat (100) @(negedge clk);
            k = n_ack;
            rd(ADDR_VECTOR, 1'b0);
            check(q[7:0], 8'h01); // odd position
            check(16'(n_ack - k), 16'h0001); // acknowledge cycle
            wait_int(1'b1); // no retrigger
        end
        k = n_ret;
        rd(ADDR_VECTOR, 1'b1);
        check(16'(n_ret - k), 16'h0001); // return cycle
    endtask

    task automatic t_scin();
        wr(ADDR_MODE, 8'h20);
        check(16'(cpin_oe), 16'h0000); // pin as input
        @(negedge clk);
        odd_irq[0] = 1'b1;
        repeat (200) @(negedge clk);
        check(16'(int_n), 16'h0001); // no edge no sample
        scin = 1'b1;
        wait_int(1'b0); // rising edge samples
        @(negedge clk);
        odd_irq[0] = 1'b0;
        scin = 1'b0;
        rd(ADDR_VECTOR, 1'b0);
        check(q[7:0], 8'h01); // external sampling
        wr(ADDR_MODE, 8'h00);
    endtask

    task automatic t_osc();
        int n;
        logic prev;
        wr(ADDR_CNT_CTRL, 8'h00);
        check(16'(cpin_oe), 16'h0001); // pin as output
        n = 0;
        prev = cpin_o;
        repeat (400) begin
            @(negedge clk);
            if (cpin_o === 1'b1 && prev === 1'b0) n++;
            prev = cpin_o;
        end
        check(16'(n), 16'h000A); // oscillator period
    endtask

    task automatic t_count();
        wr(ADDR_LCUR, 8'h40);
        wr(ADDR_CNT_CTRL, 8'h04);
        // Exactly 400 clocks run between the two control commits
        repeat (388) @(negedge clk);
        wr(ADDR_CNT_CTRL, 8'h00);
        rd(ADDR_LCUR, 1'b0);
        check(q[7:0], 8'h36); // prescaled by four
        wr(ADDR_CNT_CTRL, 8'h44);
        repeat (188) @(negedge clk);
        wr(ADDR_CNT_CTRL, 8'h00);
        rd(ADDR_LCUR, 1'b0);
        check(q[7:0], 8'h22); // one step per clock edge
        wr(ADDR_CNT_CTRL, 8'h10);
        check(16'(cpin_o), 16'h0000); // low counter not zero
        wr(ADDR_CNT_CTRL, 8'h20);
        check(16'(cpin_o), 16'h0001); // high counter zero
        wr(ADDR_CNT_CTRL, 8'h30);
        check(16'(cpin_o), 16'h0001); // either counter zero
        wr(ADDR_CNT_CTRL, 8'h00);
    endtask

    task automatic t_port();
        wr(ADDR_PORT_DATA, 8'h01);
        wr(ADDR_PORT_DIR, 8'h7E);
        wr(ADDR_PIN_FUNC, 8'h00);
        check({7'h00, gp_oe, gp_o[0]}, 16'h0103); // zero is output
        @(negedge clk);
        gp_ext = 8'hA4;
        rd(ADDR_PORT_DATA, 1'b0);
        check(q[7:0], 8'h25); // port in and out
        @(negedge clk);
        gp_ext = 8'h00;
        wr(ADDR_PIN_FUNC, 8'hFF);
        check(16'(gp_oe), 16'h0000); // one is interrupt
        wr(ADDR_OUTASN, 8'hFF);
        check(16'(gp_oe), 16'h000F); // lowest four only
        wr(ADDR_OUTASN, 8'h00);
        wr(ADDR_PORT_DIR, 8'hFF);
    endtask

    task automatic t_wide();
        wr(ADDR_MODE, 8'h01);
        cpu.xfer(1'b1, 1'b0, 1'b0, 1'b0, ADDR_LSTART, 16'h1234, q);
        cpu.xfer(1'b1, 1'b0, 1'b1, 1'b0, ADDR_HSTART, 16'hAB55, q);
        cpu.xfer(1'b0, 1'b0, 1'b0, 1'b0, ADDR_LSTART, 16'h0000, q);
        check(q, 16'h1234); // shared pins carry high byte
        cpu.xfer(1'b0, 1'b0, 1'b0, 1'b0, ADDR_HSTART, 16'h0000, q);
        check(q, 16'h0055); // high byte needs enable
        wr(ADDR_MODE, 8'h00);
        rd(ADDR_LSTART, 1'b0);
        check(q[7:0], 8'h34); // low lane both widths
    endtask

    task automatic end_sim();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #300000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (5) @(negedge clk);
        t_reset();
        t_regs();
        t_modes();
        t_scin();
        t_osc();
        t_count();
        t_port();
        t_wide();
        end_sim();
    end
endmodule
